// File: src/adcsq_consts.svh
// Constants for the converter sequencer control block
// What the document asks of this block and of its software
// RULE1: One of eight inputs routed to converter
// RULE2: Selected pin forced input, writes ignored, reads 0
// RULE3: Unselected pins stay under port control
// RULE4: Code FF at upper, 00 at lower reference
// RULE5: Register write starts conversion, 16-17 clocks
// RULE6: Software sets converter clock near 1 MHz
// RULE7: Continuous mode overwrites result every conversion
// RULE8: Continuous runs until continuous bit cleared
// RULE9: Done flag set until result read
// RULE10: Single mode: one conversion per write
// RULE11: Software discards result of interrupted conversion
// RULE12: Irq enable raises request, not flag
// RULE13: Converter runs in wait, irq wakes
// RULE14: Software powers converter down before wait
// RULE15: Stop mode aborts conversion, converter inactive
// RULE16: Conversions resume after stop; allow settling
// RULE17: Five-bit channel codes, references, power off
// RULE18: Result read clears flag; flag zero with irq
// RULE19: Result read or control write clears irq
// RULE20: Prescaler 1,2,4,8,16; source select, reset oscillator
// RULE21: Control write restarts sequencer with new settings
`ifndef ADCSQ_CONSTS_SVH
`define ADCSQ_CONSTS_SVH
`define ADCSQ_ADDR_SC 2'h0
`define ADCSQ_ADDR_DATA 2'h1
`define ADCSQ_ADDR_CLK 2'h2
`define ADCSQ_CH_REFH 5'h1d
`define ADCSQ_CH_REFL 5'h1e
`define ADCSQ_CH_OFF 5'h1f
`define ADCSQ_CODE_FULL 8'hff
`define ADCSQ_CODE_ZERO 8'h00
`define ADCSQ_SC_RESET 8'h1f
`define ADCSQ_CLK_RESET 8'h00
`define ADCSQ_CONV_CYCLES 5'h10
`define ADCSQ_SAR_BITS 4'h8
`endif

// File: src/adcsq_pkg.sv
// Types for the converter sequencer control block
package adcsq_pkg;
	typedef enum logic [1:0] {
		ADCSQ_IDLE = 2'b00,
		ADCSQ_CONV = 2'b01,
		ADCSQ_DONE = 2'b11
	} adcsq_state_type;
	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} adcsq_bus_type;
endpackage

// File: src/adcsq_top.sv
// Converter sequencer: registers, prescaler, SAR sequencing, pin override
`timescale 1ns/100ps
`include "adcsq_consts.svh"
module adcsq_top #(
	parameter int CH_NUM = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Register port
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Clock sources and power modes
	input wire logic osc_clk_tick,
	input wire logic bus_clk_tick,
	input wire logic stop_mode,
	// Comparator from analog core: input above DAC level
	input wire logic comp_above,
	output logic [7:0] dac_code_q,
	output logic [4:0] mux_sel_q,
	output logic converter_on_q,
	// Port pins shared with the converter
	input wire logic [CH_NUM-1:0] port_out,
	input wire logic [CH_NUM-1:0] port_dir,
	input wire logic [CH_NUM-1:0] pin_in,
	output logic [CH_NUM-1:0] pin_out_q,
	output logic [CH_NUM-1:0] pin_oe_q,
	output logic [CH_NUM-1:0] port_read_q,
	// Completion request
	output logic conv_irq_q
);
	adcsq_pkg::adcsq_bus_type bus;
	adcsq_pkg::adcsq_state_type state_q;
	logic conv_done_flag_q, conv_irq_enable_q, continuous_conv_enable_q;
	logic [4:0] input_channel_select_q;
	logic [2:0] conv_clock_divider_q;
	logic conv_clock_source_select_q;
	logic [7:0] result_q, sar_q;
	logic [3:0] bit_q;
	logic [4:0] cyc_q;
	logic [3:0] pre_q;
	logic [3:0] pre_max;
	// Converter clock enable, strobes and the guarded end of a conversion
	logic src_tick, conv_tick, sc_wr, data_rd, conv_end;

	// Decode of prescaler field to terminal count
	function automatic logic [3:0] div_max(input logic [2:0] code);
		if (code[2])
			div_max = 4'hf; // RULE20
		else
			div_max = 4'((5'h1 << code[1:0]) - 5'h1);
	endfunction

	// True when the field names one of the external inputs
	function automatic logic is_pin(input logic [4:0] ch);
		is_pin = (ch[4:3] == 2'b00);
	endfunction

	// Bus fields gathered into one carrier, then decoded
	assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
	assign sc_wr = bus.wr && (bus.addr == `ADCSQ_ADDR_SC);
	assign data_rd = bus.rd && (bus.addr == `ADCSQ_ADDR_DATA);
	assign pre_max = div_max(conv_clock_divider_q);
	assign src_tick = conv_clock_source_select_q ? bus_clk_tick : osc_clk_tick; // RULE20
	assign conv_tick = src_tick && (pre_q == pre_max);
	// A finish during stop is dropped; the sequencer reruns it afterwards
	assign conv_end = (state_q == adcsq_pkg::ADCSQ_DONE) && !stop_mode;

	////////////////////////////////////////////////////////////////////////////////
	// Status/control fields; a write here also kicks the sequencer
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			input_channel_select_q <= `ADCSQ_CH_OFF;
			conv_irq_enable_q <= 1'b0;
			continuous_conv_enable_q <= 1'b0;
		end
		else if (sc_wr)
		begin
			// Bit 7 is read-only; writes to it are dropped
			input_channel_select_q <= bus.wdata[4:0]; // RULE17
			continuous_conv_enable_q <= bus.wdata[5];
			conv_irq_enable_q <= bus.wdata[6];
		end
	end

	// Clock register; reset leaves the oscillator selected
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			conv_clock_divider_q <= 3'h0;
			conv_clock_source_select_q <= 1'b0; // RULE20
		end
		else if (bus.wr && bus.addr == `ADCSQ_ADDR_CLK)
		begin
			conv_clock_divider_q <= bus.wdata[7:5]; // RULE20
			conv_clock_source_select_q <= bus.wdata[4];
		end
	end

	// Prescaler; restarted on a control write so timing is clean
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			pre_q <= 4'h0;
		else if (sc_wr || stop_mode)
			pre_q <= 4'h0;
		else if (src_tick)
			pre_q <= (pre_q == pre_max) ? 4'h0 : pre_q + 4'h1; // RULE20
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer: 16 converter clocks per conversion, two per bit
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			state_q <= adcsq_pkg::ADCSQ_IDLE;
			cyc_q <= 5'h0;
			bit_q <= 4'h0;
			sar_q <= 8'h00;
		end
		else if (stop_mode)
		begin
			// Abort; a live conversion reruns from its first cycle after stop
			state_q <= (state_q == adcsq_pkg::ADCSQ_IDLE) ? adcsq_pkg::ADCSQ_IDLE
				: adcsq_pkg::ADCSQ_CONV; // RULE15 RULE16
			cyc_q <= 5'h0;
			bit_q <= 4'h0;
			sar_q <= 8'h80;
		end
		else if (sc_wr)
		begin
			// Abandon any conversion and restart with new settings
			state_q <= (bus.wdata[4:0] == `ADCSQ_CH_OFF) ? adcsq_pkg::ADCSQ_IDLE
				: adcsq_pkg::ADCSQ_CONV; // RULE5 RULE21
			cyc_q <= 5'h0;
			bit_q <= 4'h0;
			sar_q <= 8'h80;
		end
		else
		begin
			unique case (state_q)
				adcsq_pkg::ADCSQ_IDLE:
				begin
					cyc_q <= 5'h0;
				end
				adcsq_pkg::ADCSQ_CONV:
				begin
					if (conv_tick)
					begin
						cyc_q <= cyc_q + 5'h1;
						// Odd cycles resolve one bit, from MSB down
						if (cyc_q[0] && bit_q < `ADCSQ_SAR_BITS)
						begin
							sar_q <= (comp_above ? sar_q : sar_q & ~(8'h80 >> bit_q))
								| ((8'h80 >> bit_q) >> 1); // RULE4
							bit_q <= bit_q + 4'h1;
						end
						// Sixteen ticks; the last one also resolves bit zero
						if (cyc_q == `ADCSQ_CONV_CYCLES - 5'h1)
							state_q <= adcsq_pkg::ADCSQ_DONE; // RULE5
					end
				end
				adcsq_pkg::ADCSQ_DONE:
				begin
					cyc_q <= 5'h0;
					bit_q <= 4'h0;
					sar_q <= 8'h80;
					// Continuous mode starts the next one at once
					state_q <= continuous_conv_enable_q ? adcsq_pkg::ADCSQ_CONV
						: adcsq_pkg::ADCSQ_IDLE; // RULE8 RULE10
				end
				default:
					state_q <= adcsq_pkg::ADCSQ_IDLE;
			endcase
		end
	end

	// Result register, overwritten every conversion
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			result_q <= 8'h00;
		else if (conv_end)
			result_q <= sar_q; // RULE7
	end

	////////////////////////////////////////////////////////////////////////////////
	// Done flag: setting wins over a same-cycle clear
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			conv_done_flag_q <= 1'b0;
		else if (conv_end && !conv_irq_enable_q)
			conv_done_flag_q <= 1'b1; // RULE9
		else if (data_rd || conv_irq_enable_q)
			conv_done_flag_q <= 1'b0; // RULE18
	end

	// Request: set wins too, so a finished result is never lost
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			conv_irq_q <= 1'b0;
		else if (conv_end && conv_irq_enable_q)
			conv_irq_q <= 1'b1; // RULE12 RULE13
		else if (data_rd || sc_wr)
			conv_irq_q <= 1'b0; // RULE19
	end

	// Read data, one cycle after the strobe
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (bus.rd)
		begin
			unique case (bus.addr)
				`ADCSQ_ADDR_SC:
					// Flag reads 0 the moment requests are enabled
					reg_rdata <= {conv_done_flag_q && !conv_irq_enable_q, conv_irq_enable_q, // RULE18
						continuous_conv_enable_q, input_channel_select_q};
				`ADCSQ_ADDR_DATA:
					reg_rdata <= result_q;
				`ADCSQ_ADDR_CLK:
					reg_rdata <= {conv_clock_divider_q, conv_clock_source_select_q, 4'h0};
				default:
					reg_rdata <= 8'h00;
			endcase
		end
		else
			reg_rdata <= 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Trial code and channel to the analog core
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			dac_code_q <= 8'h00;
			mux_sel_q <= `ADCSQ_CH_OFF;
		end
		else
		begin
			// Lags the SAR by a cycle; bits resolve only every other tick
			dac_code_q <= sar_q;
			mux_sel_q <= input_channel_select_q; // RULE1 RULE17
		end
	end

	// Power: off code or stop mode shut the converter down
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			converter_on_q <= 1'b0;
		else
			converter_on_q <= (input_channel_select_q != `ADCSQ_CH_OFF) && !stop_mode; // RULE15
	end

	// Pin override, one generate slice per shared pin
	genvar gi;
	generate
		for (gi = 0; gi < CH_NUM; gi++)
		begin : g_pin
			logic taken;
			assign taken = is_pin(input_channel_select_q)
				&& (input_channel_select_q[2:0] == 3'(gi));
			// Drive level: parked low while the converter owns the pin
			always_ff @(posedge clk_sys or posedge rst)
			begin
				if (rst)
					pin_out_q[gi] <= 1'b0;
				else
					pin_out_q[gi] <= taken ? 1'b0 : port_out[gi]; // RULE2 RULE3
			end

			// Enable: a selected pin is forced to input
			always_ff @(posedge clk_sys or posedge rst)
			begin
				if (rst)
					pin_oe_q[gi] <= 1'b0;
				else
					pin_oe_q[gi] <= taken ? 1'b0 : port_dir[gi]; // RULE2 RULE3
			end

			// Port read: the selected pin reads 0
			always_ff @(posedge clk_sys or posedge rst)
			begin
				if (rst)
					port_read_q[gi] <= 1'b0;
				else
					port_read_q[gi] <= taken ? 1'b0 : pin_in[gi]; // RULE2 RULE3
			end
		end
	endgenerate
endmodule

// File: verification/adcsq_analog_model.sv
// Analog side: channel levels and the comparator
`timescale 1ns/100ps
module adcsq_analog_model (
	// Converter side
	input wire logic [7:0] dac_code_q,
	input wire logic [4:0] mux_sel_q,
	input wire logic [63:0] levels,
	// Comparator
	output logic comp_above
);
	logic [7:0] lvl;
	// Routed level; references sit at the scale ends
	always_comb
	begin
		case (mux_sel_q)
			5'h1d: lvl = 8'hff;
			5'h1e: lvl = 8'h00;
			default: lvl = levels[mux_sel_q[2:0]*8 +: 8];
		endcase
		comp_above = lvl >= dac_code_q;
	end
endmodule

// File: verification/adcsq_sva.sv
// Port checker for the converter sequencer, with its bind
`timescale 1ns/100ps
module adcsq_sva #(parameter int CH_NUM = 8) (
	// Clock, reset, register port
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [1:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	// Modes and converter
	input wire logic stop_mode,
	input wire logic [4:0] mux_sel_q,
	input wire logic converter_on_q,
	input wire logic conv_irq_q,
	// Pins
	input wire logic [CH_NUM-1:0] port_dir,
	input wire logic [CH_NUM-1:0] pin_oe_q,
	input wire logic [CH_NUM-1:0] port_read_q
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	//////////
	sel_follow_a: assert property (reg_wr && reg_addr == 2'h0 |-> ##2
		mux_sel_q == $past(reg_wdata[4:0], 2)) else $error("channel not taken");
	sel_pin_in_a: assert property ($stable(mux_sel_q) && mux_sel_q < 5'h08 |->
		!pin_oe_q[mux_sel_q[2:0]] && !port_read_q[mux_sel_q[2:0]]) else $error("pin driven");
	unsel_pin_a: assert property (!$past(rst) && $stable(mux_sel_q) &&
		mux_sel_q[4:3] != 2'h0 |-> pin_oe_q == $past(port_dir)) else $error("port lost");
	irq_wr_clr_a: assert property (reg_wr && reg_addr == 2'h0 |=> !conv_irq_q)
		else $error("irq kept on write");
	irq_rd_clr_a: assert property (reg_rd && reg_addr == 2'h1 |=> !conv_irq_q)
		else $error("irq kept on read");
	conv_min_a: assert property (reg_wr && reg_addr == 2'h0 |=> (!conv_irq_q) [*8])
		else $error("conversion too short");
	stop_idle_a: assert property (stop_mode [*2] |-> !$rose(conv_irq_q))
		else $error("done in stop");
	power_off_a: assert property ((mux_sel_q == 5'h1f) [*2] |-> !converter_on_q)
		else $error("converter on");
	// Main scenarios
	cover property ($rose(conv_irq_q));
	cover property (reg_rd && reg_addr == 2'h1);
	cover property (stop_mode ##1 !stop_mode);
endmodule
bind adcsq_top adcsq_sva #(.CH_NUM(CH_NUM)) i_adcsq_sva (.*);

// File: verification/adcsq_top_tb.sv
// Random and corner stimulus for the converter sequencer
`timescale 1ns/100ps
module adcsq_top_tb;
	logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, stop_mode = 1'b0;
	logic osc_clk_tick = 1'b0, bus_clk_tick = 1'b0;
	logic [1:0] reg_addr = 2'h0;
	logic [7:0] reg_wdata = 8'h00, port_out = 8'h00, port_dir = 8'h00, pin_in = 8'h00;
	logic [63:0] levels = 64'h0;
	logic [31:0] rs = 32'h63;
	logic [7:0] reg_rdata, dac_code_q, pin_out_q, pin_oe_q, port_read_q, d;
	logic [4:0] mux_sel_q, ch;
	logic converter_on_q, conv_irq_q, comp_above;
	int n_errors = 0;
	int samples_checked = 0;
	adcsq_top i_adcsq_top (.*);
	adcsq_analog_model i_adcsq_analog_model (.*);
	//////////
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	// Expected code of a channel
	function automatic logic [7:0] ex(input logic [4:0] c);
		return c == 5'h1d ? 8'hff : c == 5'h1e ? 8'h00 : levels[c[2:0]*8 +: 8];
	endfunction
	task automatic wr(input logic [1:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [1:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic results;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Bounded wait on irq or on the done flag
	task automatic wt(input logic irq);
		for (int k = 0; k < 3000; k++)
		begin
			if (irq)
				@(negedge clk_sys);
			else
				rd(2'h0, d);
			if (irq ? conv_irq_q === 1'b1 : d[7] === 1'b1)
				return;
		end
		n_errors++;
		results();
	endtask
	//////////
	initial
	begin
		forever #2.5 clk_sys = ~clk_sys;
	end
	// Port side and clock ticks churn every cycle
	always @(posedge clk_sys)
	begin
		rs <= xs(rs);
		{osc_clk_tick, bus_clk_tick, pin_in, port_dir, port_out} <= rs[25:0];
	end
	initial
	begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		rd(2'h0, d);
		chk(d, 8'h1f);
		rd(2'h2, d);
		chk(d, 8'h00);
		wr(2'h3, 8'h5a);
		rd(2'h3, d);
		chk(d, 8'h00);
		// Every channel and reference, every divider, both sources
		for (int i = 0; i < 10; i++)
		begin
			ch = i < 8 ? 5'(i) : 5'(i) + 5'h15;
			levels <= {rs, rs ^ 32'h5a5a};
			wr(2'h2, {3'(i), i[0], 4'h0});
			wr(2'h0, {1'b0, i[1], 1'b0, ch});
			wt(i[1]);
			if (i < 8)
				chk({6'h0, pin_oe_q[ch[2:0]], port_read_q[ch[2:0]]}, 8'h00);
			rd(2'h0, d);
			chk({7'h0, d[7]}, {7'h0, !i[1]});
			rd(2'h1, d);
			chk(d, ex(ch));
			rd(2'h0, d);
			chk({d[7], 6'h0, conv_irq_q}, 8'h00);
		end
		// Level moves mid-run; the spoiled result is thrown away
		wr(2'h0, 8'h23);
		wt(1'b0);
		levels <= ~levels;
		rd(2'h1, d);
		wt(1'b0);
		rd(2'h1, d);
		wt(1'b0);
		rd(2'h1, d);
		chk(d, ex(5'h03));
		wr(2'h0, 8'h03);
		wt(1'b0);
		rd(2'h1, d);
		chk(d, ex(5'h03));
		repeat (400) @(posedge clk_sys);
		rd(2'h0, d);
		chk({7'h0, d[7]}, 8'h00);
		wr(2'h0, 8'h63);
		stop_mode <= 1'b1;
		repeat (300) @(negedge clk_sys);
		chk({7'h0, conv_irq_q}, 8'h00);
		@(posedge clk_sys);
		stop_mode <= 1'b0;
		wt(1'b1);
		rd(2'h1, d);
		wr(2'h0, 8'h1f);
		repeat (3) @(negedge clk_sys);
		chk({7'h0, converter_on_q}, 8'h00);
		results();
	end
endmodule
